/* File: field_sync_register_shadowing.sv */
// register bank with field-synchronised write and read buffering
// shadow, active and captured copies of all byte registers
// assumes host bus and video timing inputs are synchronous to clk_sys
// assumes status sources are stable while the capture strobe stands
`timescale 1ns/1ps
module field_sync_register_shadowing
    import shadow_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host register port
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostAddr,
    input wire logic [7:0] hostWdata,
    output logic [7:0] hostRdata,
    output logic hostRvalid,
    // video timing
    input wire logic mainOutputReadEnable,
    input wire logic readStartReset,
    input wire logic firstMemoryReadEnable,
    input wire logic secondMemoryReadEnable,
    input wire logic lineStart,
    input wire logic halfActiveReached,
    // internal status sources, one byte per address
    input wire logic [2047:0] statusIn,
    // register outputs to datapath
    output logic [2047:0] activeRegs,
    output logic powerOnResetPulse,
    output logic candidateSelectBit,
    output logic fieldStart,
    output logic readbackCapture
);
    // ************
    // types
    // ************
    typedef logic [DATA_W-1:0] reg_byte_t;
    typedef logic [NUM_REGS-1:0][DATA_W-1:0] byte_bank_t;

    // ************
    // state
    // ************
    typedef struct packed {
        byte_bank_t shadow;
        byte_bank_t active;
        byte_bank_t captured;
        reg_byte_t rdata;
        logic rvalid;
        logic porPulse;
        logic candBit;
    } bank_s;

    bank_s cur_ff;
    bank_s nxt_cur;

    // ************
    // decode nets
    // ************
    byte_bank_t statusBytes;

    logic writePor;
    logic writeCand;

    logic liveAddr;
    reg_byte_t liveByte;
    reg_byte_t heldByte;
    reg_byte_t readByte;

    // ************
    // reset image
    // ************
    // every stored byte at its reset value
    function automatic bank_s resetState();
        bank_s init;
        init = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            init.shadow[i] = RESET_VALUE;
            init.active[i] = RESET_VALUE;
            init.captured[i] = RESET_VALUE;
        end
        return init;
    endfunction : resetState

    localparam bank_s RESET_STATE = resetState();

    // ************
    // helpers
    // ************
    // byte with only the candidate select bit replaced
    function automatic reg_byte_t withCandBit(
        input reg_byte_t oldByte,
        input logic newBit
    );
        reg_byte_t merged;
        merged = oldByte;
        merged[CAND_SELECT_BIT] = newBit;
        return merged;
    endfunction : withCandBit

    // write strobe aimed at one address
    function automatic logic writeHits(
        input logic wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return wr && (addr == target);
    endfunction : writeHits

    // one byte of a bank by address
    function automatic reg_byte_t byteAt(
        input byte_bank_t bank,
        input logic [ADDR_W-1:0] addr
    );
        return bank[addr];
    endfunction : byteAt

    // ************
    // strobe generator
    // ************
    strobe_gen u_strobe_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mainOutputReadEnable(mainOutputReadEnable),
        .readStartReset(readStartReset),
        .firstMemoryReadEnable(firstMemoryReadEnable),
        .secondMemoryReadEnable(secondMemoryReadEnable),
        .lineStart(lineStart),
        .halfActiveReached(halfActiveReached),
        .fieldStart(fieldStart),
        .readbackCapture(readbackCapture)
    );

    // ************
    // address decode
    // ************
    assign statusBytes = statusIn;
    assign writePor = writeHits(hostWrite, hostAddr, ADDR_POR_TRIGGER);
    assign writeCand = writeHits(hostWrite, hostAddr, ADDR_CAND_CONTROL);
    assign liveAddr = isLive(hostAddr);
    assign liveByte = byteAt(statusBytes, hostAddr);
    assign heldByte = byteAt(cur_ff.captured, hostAddr);

    // ************
    // read source select
    // ************
    assign readByte = liveAddr ? liveByte : heldByte;

    // ************
    // next state
    // ************
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rvalid = 1'h0;
        nxt_cur.porPulse = 1'h0;

        // ************
        // shadow write, later write overwrites
        // ************
        if (hostWrite) begin
            nxt_cur.shadow[hostAddr] = hostWdata;
        end

        // ************
        // whole shadow goes live at field start
        // ************
        if (fieldStart) begin
            nxt_cur.active = nxt_cur.shadow;
        end

        // ************
        // reset trigger skips the shadow
        // ************
        if (writePor) begin
            nxt_cur.porPulse = 1'h1;
            nxt_cur.active[ADDR_POR_TRIGGER] = hostWdata;
        end

        // ************
        // candidate select bit skips the shadow
        // ************
        if (writeCand) begin
            nxt_cur.candBit = hostWdata[CAND_SELECT_BIT];
            nxt_cur.active[ADDR_CAND_CONTROL] = withCandBit(
                nxt_cur.active[ADDR_CAND_CONTROL],
                hostWdata[CAND_SELECT_BIT]
            );
        end

        // ************
        // status snapshot at readback strobe
        // ************
        if (readbackCapture) begin
            nxt_cur.captured = statusBytes;
        end

        // ************
        // read answer one cycle after request
        // ************
        if (hostRead) begin
            nxt_cur.rvalid = 1'h1;
            nxt_cur.rdata = readByte;
        end
    end

    // ************
    // register
    // ************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= RESET_STATE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ************
    // outputs
    // ************
    assign hostRdata = cur_ff.rdata;
    assign hostRvalid = cur_ff.rvalid;
    assign powerOnResetPulse = cur_ff.porPulse;
    assign candidateSelectBit = cur_ff.candBit;
    assign activeRegs = cur_ff.active;
endmodule : field_sync_register_shadowing

/* File: shadow_pkg.sv */
// package for the field-synchronised register shadowing block
// assumes one clock domain; video timing strobes arrive as plain inputs
package shadow_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 256;
    localparam logic [7:0] ADDR_POR_TRIGGER = 8'h25;
    localparam logic [7:0] ADDR_CAND_CONTROL = 8'h2F;
    localparam int CAND_SELECT_BIT = 1;
    localparam logic [7:0] ADDR_LIVE_LO = 8'hB0;
    localparam logic [7:0] ADDR_LIVE_HI = 8'hBF;
    localparam logic [7:0] ADDR_LIVE_X0 = 8'hAE;
    localparam logic [7:0] ADDR_LIVE_X1 = 8'hAF;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int BLANK_LINE_CAPTURE = 4;
    localparam logic [2:0] BLANK_LINE_CAPTURE_3 = 3'h4;

    function automatic logic isLive(input logic [7:0] addr);
        isLive = ((addr >= ADDR_LIVE_LO) && (addr <= ADDR_LIVE_HI)) ||
                 (addr == ADDR_LIVE_X0) || (addr == ADDR_LIVE_X1);
    endfunction : isLive
endpackage : shadow_pkg

/* File: strobe_gen.sv */
// strobe generator: field start and readback capture
// assumes video timing inputs already synchronised to clk_sys
`timescale 1ns/1ps
module strobe_gen
    import shadow_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // video timing
    input wire logic mainOutputReadEnable,
    input wire logic readStartReset,
    input wire logic firstMemoryReadEnable,
    input wire logic secondMemoryReadEnable,
    input wire logic lineStart,
    input wire logic halfActiveReached,
    // strobes
    output logic fieldStart,
    output logic readbackCapture
);
    typedef struct packed {
        logic reOutPrev;
        logic armed;
        logic memRePrev;
        logic counting;
        logic [2:0] blankLine;
        logic fieldStart;
        logic capture;
    } strobe_s;

    strobe_s cur_ff;
    strobe_s nxt_cur;
    logic memRe;

    assign memRe = firstMemoryReadEnable | secondMemoryReadEnable;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.reOutPrev = mainOutputReadEnable;
        nxt_cur.memRePrev = memRe;
        nxt_cur.fieldStart = 1'h0;
        nxt_cur.capture = 1'h0;
        // field start on first rising read enable after reset pulse
        if (readStartReset) begin
            nxt_cur.armed = 1'h1;
        end else if (cur_ff.armed && mainOutputReadEnable && !cur_ff.reOutPrev) begin
            nxt_cur.armed = 1'h0;
            nxt_cur.fieldStart = 1'h1;
        end
        // blanking line count from end of memory read enables
        if (cur_ff.memRePrev && !memRe) begin
            nxt_cur.counting = 1'h1;
            nxt_cur.blankLine = 3'h1;
        end else if (cur_ff.counting && lineStart) begin
            // stop after the capture line so the count cannot wrap
            if (cur_ff.blankLine == BLANK_LINE_CAPTURE_3) begin
                nxt_cur.counting = 1'h0;
            end else begin
                nxt_cur.blankLine = cur_ff.blankLine + 3'h1;
            end
        end
        if (cur_ff.counting && (cur_ff.blankLine == BLANK_LINE_CAPTURE_3) && halfActiveReached) begin
            nxt_cur.capture = 1'h1;
            nxt_cur.counting = 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign fieldStart = cur_ff.fieldStart;
    assign readbackCapture = cur_ff.capture;
endmodule : strobe_gen

/* File: field_sync_props.sv */
// assertions on shadowing block ports
// bound to the block, one clock
`timescale 1ns/1ps
module field_sync_props
    import shadow_pkg::*;
(
    // watched ports
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostAddr,
    input wire logic hostRvalid,
    input wire logic mainOutputReadEnable,
    input wire logic readStartReset,
    input wire logic halfActiveReached,
    input wire logic [2047:0] activeRegs,
    input wire logic powerOnResetPulse,
    input wire logic fieldStart,
    input wire logic readbackCapture
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence armSeq;
        readStartReset ##1 !mainOutputReadEnable ##1 mainOutputReadEnable;
    endsequence
    read_answer_a: assert property (hostRead |=> hostRvalid) else $error("no rvalid");
    field_start_a: assert property (armSeq |=> fieldStart) else $error("no start");
    start_once_a: assert property (fieldStart |=> !fieldStart) else $error("long start");
    active_hold_a: assert property (!fieldStart |=> $stable(activeRegs[135:128])) else $error("early");
    reset_pulse_a: assert property (hostWrite && hostAddr == ADDR_POR_TRIGGER |=> powerOnResetPulse)
        else $error("no pulse");
    capture_cause_a: assert property (readbackCapture |-> $past(halfActiveReached)) else $error("stray");
    capture_once_a: assert property (readbackCapture |=> !readbackCapture) else $error("long");
endmodule : field_sync_props
bind field_sync_register_shadowing field_sync_props u_field_sync_props (.*);

/* File: host_model.sv */
// host model: one register cycle per call
// shares clk_sys with the block
`timescale 1ns/1ps
module host_model (
    // host port
    input wire logic clk_sys,
    output logic hostWrite = 1'h0,
    output logic hostRead = 1'h0,
    output logic [7:0] hostAddr = 8'h00,
    output logic [7:0] hostWdata = 8'h00
);
    task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys) {hostWrite, hostRead, hostAddr, hostWdata} = {wr, !wr, a, d};
        @(negedge clk_sys) {hostWrite, hostRead, hostAddr, hostWdata} = {2'h0, ~a, ~d};
    endtask : xfer
endmodule : host_model

/* File: test_field_sync_register_shadowing.sv */
// bench: host cycles plus video timing
// inputs change at falling edge
`timescale 1ns/1ps
module test_field_sync_register_shadowing import shadow_pkg::*; ;
    logic clk_sys = 1'h0, rst_n = 1'h0, hostWrite, hostRead, hostRvalid, powerOnResetPulse, fieldStart;
    logic candidateSelectBit, readbackCapture, lineStart = 1'h0, halfActiveReached = 1'h0;
    logic mainOutputReadEnable = 1'h0, readStartReset = 1'h0;
    logic firstMemoryReadEnable = 1'h0, secondMemoryReadEnable = 1'h0;
    logic [7:0] hostAddr, hostWdata, hostRdata;
    logic [2047:0] statusIn = '0, activeRegs;
    int err_total = 0, comparisons = 0, n;
    always #4 clk_sys = ~clk_sys;
    field_sync_register_shadowing u_field_sync_register_shadowing (.*);
    host_model u_host_model (.*);
    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
            err_total++;
        end
    endtask : chk
    task complete_run;
        $display("mismatches %0d compares %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'h1;
        u_host_model.xfer(1'h1, ADDR_POR_TRIGGER, 8'h01);
        chk({7'h00, powerOnResetPulse}, 8'h01);
        chk(activeRegs[303:296], 8'h01);
        u_host_model.xfer(1'h1, ADDR_CAND_CONTROL, 8'h02);
        chk({7'h00, candidateSelectBit}, 8'h01);
        chk(activeRegs[383:376], 8'h02);
        u_host_model.xfer(1'h1, 8'h10, 8'h5A);
        u_host_model.xfer(1'h1, 8'h10, 8'hA5);
        chk(activeRegs[135:128], RESET_VALUE);
        readStartReset = 1'h1;
        @(negedge clk_sys) readStartReset = 1'h0;
        @(negedge clk_sys) mainOutputReadEnable = 1'h1;
        for (n = 0; n < 9 && fieldStart !== 1'h1; n++) @(negedge clk_sys);
        chk({7'h00, fieldStart}, 8'h01);
        if (n > 8) complete_run;
        @(negedge clk_sys) chk(activeRegs[135:128], 8'hA5);
        chk({7'h00, candidateSelectBit}, 8'h01);
        statusIn[519:512] = 8'h3C;
        statusIn[1455:1448] = 8'h77;
        statusIn[1399:1392] = 8'h5C;
        u_host_model.xfer(1'h0, 8'h40, 8'h00);
        chk(hostRdata, RESET_VALUE);
        chk({7'h00, hostRvalid}, 8'h01);
        u_host_model.xfer(1'h0, 8'hB5, 8'h00);
        chk(hostRdata, 8'h77);
        u_host_model.xfer(1'h0, 8'hAE, 8'h00);
        chk(hostRdata, 8'h5C);
        {firstMemoryReadEnable, secondMemoryReadEnable} = 2'h3;
        @(negedge clk_sys) {firstMemoryReadEnable, secondMemoryReadEnable} = 2'h0;
        repeat (3) begin
            @(negedge clk_sys) lineStart = 1'h1;
            @(negedge clk_sys) lineStart = 1'h0;
        end
        @(negedge clk_sys) halfActiveReached = 1'h1;
        @(negedge clk_sys) halfActiveReached = 1'h0;
        for (n = 0; n < 9 && readbackCapture !== 1'h1; n++) @(negedge clk_sys);
        chk({7'h00, readbackCapture}, 8'h01);
        if (n > 8) complete_run;
        repeat (2) @(negedge clk_sys);
        statusIn[519:512] = 8'h11;
        u_host_model.xfer(1'h0, 8'h40, 8'h00);
        chk(hostRdata, 8'h3C);
        complete_run;
    end
endmodule : test_field_sync_register_shadowing
